// >>> design/tws_pkg.sv
// package for the two-wire serial memory target: memory shape, select byte,
// write-cycle timing and the map of the AHB-Lite control registers.
// assumes a 40 MHz system clock; nothing else is shared.
package tws_pkg;

  // memory organisation
  localparam int PAGE_COUNT  = 256;
  localparam int PAGE_BYTES  = 64;
  localparam int MEM_BYTES   = PAGE_COUNT * PAGE_BYTES;
  localparam int ADDR_W      = 14;
  localparam int OFS_W       = 6;
  localparam int BYTE_W      = 8;

  // serial framing
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [3:0] DEV_PREFIX  = 4'hA;

  // internal write cycle timing, longest time rounds down
  localparam int CLK_PERIOD_NS = 25;
  localparam int WR_TIME_MS    = 5;
  localparam int WR_CYCLES_DFLT = (WR_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CNT_W         = 20;

  // pin synchroniser layout: {wp, strap2, strap1, strap0, sda, scl}
  localparam int         PIN_W     = 6;
  localparam logic [5:0] PIN_RESET = 6'h03;

  // register map, byte addresses
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] STATUS_OFF    = 8'h04;
  localparam int         CTRL_EN_BIT   = 0;
  localparam logic       CTRL_EN_RESET = 1'b1;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_WP_BIT   = 1;
  localparam int         STAT_ADDR_LSB = 8;

  // byte kinds inside a transfer
  localparam logic [1:0] K_DEV  = 2'h0;
  localparam logic [1:0] K_HI   = 2'h1;
  localparam logic [1:0] K_LO   = 2'h2;
  localparam logic [1:0] K_DATA = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h2,
    ST_TX   = 3'h3,
    ST_MACK = 3'h4
  } tws_state_t;

  typedef struct packed {
    tws_state_t        state;
    logic [1:0]        kind;
    logic [3:0]        bitcnt;
    logic [7:0]        shreg;
    logic              rw;
    logic              mack;
    logic [ADDR_W-1:0] word_addr;
    logic              oe_n;
    logic              wr_pend;
    logic              busy;
    logic [CNT_W-1:0]  wcnt;
    logic [63:0]       mask;
    logic              scl_q;
    logic              sda_q;
    logic              ctrl_en;
    logic              ahb_wr;
    logic [7:0]        ahb_addr;
    logic [31:0]       hrdata;
  } tws_regs_t;

endpackage

// >>> design/tws_pin_sync.sv
// three-flop synchroniser with agreement filter for asynchronous pins.
// assumes each bit is a slow level from outside the clk_sys domain.
`timescale 1ns/1ps
module tws_pin_sync
  import tws_pkg::*;
#(
  parameter int             WIDTH     = PIN_W,
  parameter logic [5:0]     RESET_VAL = PIN_RESET
)
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_filt
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // the filtered level moves only once stages two and three agree
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          s1          <= RESET_VAL[gi];
          s2          <= RESET_VAL[gi];
          s3          <= RESET_VAL[gi];
          pin_filt[gi] <= RESET_VAL[gi];
        end
        else
        begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            pin_filt[gi] <= s3;
        end
      end
    end
  endgenerate

endmodule // tws_pin_sync

// >>> design/tws_target.sv
// two-wire serial memory target: 16 KiB array, page buffer, timed write
// cycle, and an AHB-Lite slave with a control and a status word.
// assumes scl and sda arrive asynchronously and are far slower than clk_sys;
// the sda wire level is resolved outside from sda_out and sda_oe_n.
//
// Contract
// - sample data on scl rise, drive on fall
// - sda only pulled low or released
// - answer only when strap bits match
// - floating straps read as zero
// - write protect high blocks array writes
// - floating write protect reads low
// - 256 pages of 64 bytes
// - 14-bit word address, low six in page
// - page writes up to 64 bytes, partial allowed
// - self-timed write cycle, at most 5 ms
// - start/stop are sda edges with scl high
// - eight-bit bytes, ack low on ninth clock
// - select byte is prefix, straps, direction
// - page write wraps within the page
`timescale 1ns/1ps
module tws_target
  import tws_pkg::*;
#(
  parameter int WR_CYCLES = WR_CYCLES_DFLT
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // two-wire link
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // straps and protection
  input  wire logic        strap_addr_bit0,
  input  wire logic        strap_addr_bit1,
  input  wire logic        strap_addr_bit2,
  input  wire logic        write_protect,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  tws_regs_t         st;
  tws_regs_t         next_st;
  logic [7:0]        mem [MEM_BYTES];
  logic [7:0]        pbuf [PAGE_BYTES];
  logic [7:0]        rd_byte;
  logic [PIN_W-1:0]  pins_f;
  logic              s_scl;
  logic              s_sda;
  logic [2:0]        straps;
  logic              wp_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              is_start;
  logic              is_stop;
  logic              pbuf_we;
  logic              mem_we;
  logic              load_tx;
  logic              dev_match;
  logic              ahb_go;

  // every pin, straps and protect included, crosses through the filter;
  // unconnected straps and protect are pulled low at the pad
  tws_pin_sync u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_raw  ({write_protect, strap_addr_bit2, strap_addr_bit1,
                strap_addr_bit0, sda_in, scl}),
    .pin_filt (pins_f)
  );

  assign s_scl  = pins_f[0];
  assign s_sda  = pins_f[1];
  assign straps = pins_f[4:2];
  assign wp_s   = pins_f[5];

  // link events seen on the filtered levels
  assign scl_rise = s_scl & ~st.scl_q;
  assign scl_fall = ~s_scl & st.scl_q;
  assign is_start = s_scl & st.scl_q & st.sda_q & ~s_sda;
  assign is_stop  = s_scl & st.scl_q & ~st.sda_q & s_sda;

  // select byte: fixed prefix, strap bits, direction in bit 0
  assign dev_match = (st.shreg[7:4] == DEV_PREFIX)
                   && (st.shreg[3:1] == straps)
                   && !st.busy && st.ctrl_en;

  assign ahb_go = hsel & htrans[1] & hready;

  // open drain: the only driven level is low
  assign sda_out   = 1'b0;
  assign sda_oe_n  = st.oe_n;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.hrdata;

  // next-state logic for protocol, write cycle and register slave
  always_comb
  begin
    next_st  = st;
    pbuf_we  = 1'b0;
    mem_we   = 1'b0;
    load_tx  = 1'b0;
    next_st.scl_q = s_scl;
    next_st.sda_q = s_sda;

    // write cycle: copy marked bytes first, then run out the timer
    if (st.busy)
    begin
      mem_we = (st.wcnt < CNT_W'(PAGE_BYTES)) && st.mask[st.wcnt[OFS_W-1:0]];
      next_st.wcnt = st.wcnt + CNT_W'(1);
      if (st.wcnt == CNT_W'(WR_CYCLES - 1))
      begin
        next_st.busy = 1'b0;
        next_st.mask = '0;
        next_st.wcnt = '0;
      end
    end

    if (is_stop)
    begin
      next_st.state   = ST_IDLE;
      next_st.oe_n    = 1'b1;
      next_st.wr_pend = 1'b0;
      // stop after accepted data starts the nonvolatile write
      if (st.wr_pend && (|st.mask) && !st.busy)
      begin
        next_st.busy = 1'b1;
        next_st.wcnt = '0;
      end
    end
    else if (is_start)
    begin
      // a restart abandons any page data not closed by a stop
      next_st.state   = ST_RX;
      next_st.kind    = K_DEV;
      next_st.bitcnt  = '0;
      next_st.oe_n    = 1'b1;
      next_st.wr_pend = 1'b0;
      if (!st.busy)
        next_st.mask = '0;
    end
    else
    begin
      unique case (st.state)
        ST_IDLE :
        begin
          next_st.oe_n = 1'b1;
        end
        ST_RX :
        begin
          if (scl_rise)
          begin
            next_st.shreg  = {st.shreg[6:0], s_sda};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          else if (scl_fall && (st.bitcnt == BYTE_BITS))
          begin
            next_st.state  = ST_ACK;
            next_st.oe_n   = 1'b0;
            next_st.bitcnt = '0;
            unique case (st.kind)
              K_DEV :
              begin
                next_st.rw = st.shreg[0];
                if (!dev_match)
                begin
                  next_st.state = ST_IDLE;
                  next_st.oe_n  = 1'b1;
                end
              end
              K_HI :
              begin
                next_st.word_addr[ADDR_W-1:BYTE_W] = st.shreg[ADDR_W-BYTE_W-1:0];
              end
              K_LO :
              begin
                next_st.word_addr[BYTE_W-1:0] = st.shreg;
              end
              K_DATA :
              begin
                if (!wp_s)
                begin
                  pbuf_we         = 1'b1;
                  next_st.wr_pend = 1'b1;
                  next_st.mask[st.word_addr[OFS_W-1:0]] = 1'b1;
                end
                // only the in-page offset advances
                next_st.word_addr[OFS_W-1:0] = st.word_addr[OFS_W-1:0] + 6'h01;
              end
            endcase
          end
        end
        ST_ACK :
        begin
          // ack is held through the ninth clock, dropped on its fall
          if (scl_fall)
          begin
            next_st.oe_n = 1'b1;
            if ((st.kind == K_DEV) && st.rw)
              load_tx = 1'b1;
            else
            begin
              next_st.state = ST_RX;
              next_st.kind  = (st.kind == K_DATA) ? K_DATA : st.kind + 2'h1;
            end
          end
        end
        ST_TX :
        begin
          if (scl_fall)
          begin
            if (st.bitcnt == LAST_BIT)
            begin
              next_st.state = ST_MACK;
              next_st.oe_n  = 1'b1;
            end
            else
            begin
              next_st.shreg  = {st.shreg[6:0], 1'b0};
              next_st.oe_n   = st.shreg[6];
              next_st.bitcnt = st.bitcnt + 4'h1;
            end
          end
        end
        ST_MACK :
        begin
          if (scl_rise)
            next_st.mack = ~s_sda;
          else if (scl_fall)
          begin
            if (st.mack)
              load_tx = 1'b1;
            else
              next_st.state = ST_IDLE;
          end
        end
        default :
        begin
          next_st.state = ST_IDLE;
          next_st.oe_n  = 1'b1;
        end
      endcase
    end

    // first data bit goes out on the fall that ends the ack clock;
    // reads roll over across the whole array
    if (load_tx)
    begin
      next_st.state     = ST_TX;
      next_st.shreg     = rd_byte;
      next_st.oe_n      = rd_byte[7];
      next_st.bitcnt    = '0;
      next_st.mack      = 1'b0;
      next_st.word_addr = st.word_addr + 14'h0001;
    end

    // ahb-lite: write data lands in the data phase, read data is
    // registered during the address phase, zero wait states
    if (st.ahb_wr && (st.ahb_addr == CTRL_OFF))
      next_st.ctrl_en = hwdata[CTRL_EN_BIT];
    next_st.ahb_wr = ahb_go & hwrite;
    if (ahb_go)
    begin
      next_st.ahb_addr = haddr[7:0];
      next_st.hrdata   = '0;
      if (!hwrite && (haddr[7:0] == CTRL_OFF))
        next_st.hrdata[CTRL_EN_BIT] = st.ctrl_en;
      else if (!hwrite && (haddr[7:0] == STATUS_OFF))
      begin
        next_st.hrdata[STAT_BUSY_BIT] = st.busy;
        next_st.hrdata[STAT_WP_BIT]   = wp_s;
        next_st.hrdata[STAT_ADDR_LSB +: ADDR_W] = st.word_addr;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st         <= '0;
      st.state   <= ST_IDLE;
      st.oe_n    <= 1'b1;
      st.scl_q   <= 1'b1;
      st.sda_q   <= 1'b1;
      st.ctrl_en <= CTRL_EN_RESET;
    end
    else
      st <= next_st;
  end

  // array and page buffer: no reset, contents survive like the real cells
  always_ff @(posedge clk_sys)
  begin
    rd_byte <= mem[st.word_addr];
    if (pbuf_we)
      pbuf[st.word_addr[OFS_W-1:0]] <= st.shreg;
    if (mem_we)
      mem[{st.word_addr[ADDR_W-1:OFS_W], st.wcnt[OFS_W-1:0]}] <= pbuf[st.wcnt[OFS_W-1:0]];
  end

  // checks on the protocol engine
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_byte_in;
    (st.state == ST_RX) && scl_fall && (st.bitcnt == BYTE_BITS) && !is_start && !is_stop;
  endsequence

  sequence s_ack_entered;
    (st.state == ST_ACK) && !sda_oe_n;
  endsequence

  property p_drive_on_fall;
    ($changed(sda_oe_n) && !$past(is_start) && !$past(is_stop)) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall : assert property (p_drive_on_fall)
    else $error("sda drive changed away from an scl fall");

  property p_low_only_when_owned;
    !sda_oe_n |-> ((st.state == ST_ACK) || (st.state == ST_TX));
  endproperty
  a_low_only_when_owned : assert property (p_low_only_when_owned)
    else $error("sda pulled low outside ack or read data");

  property p_select_match;
    ((st.state == ST_ACK) && (st.kind == K_DEV))
      |-> (st.shreg[7:4] == DEV_PREFIX) && (st.shreg[3:1] == straps);
  endproperty
  a_select_match : assert property (p_select_match)
    else $error("select acknowledged without prefix and strap match");

  property p_wp_blocks;
    pbuf_we |-> !wp_s;
  endproperty
  a_wp_blocks : assert property (p_wp_blocks)
    else $error("data accepted into page while write protect high");

  property p_wr_bound;
    st.busy |-> (st.wcnt < CNT_W'(WR_CYCLES));
  endproperty
  a_wr_bound : assert property (p_wr_bound)
    else $error("write cycle ran past its limit");

  property p_wr_ends;
    (st.busy && (st.wcnt == CNT_W'(WR_CYCLES - 1))) |=> !st.busy;
  endproperty
  a_wr_ends : assert property (p_wr_ends)
    else $error("write cycle did not end on time");

  property p_start_rearms;
    is_start |=> (st.state == ST_RX) && (st.bitcnt == 4'h0) && (st.kind == K_DEV);
  endproperty
  a_start_rearms : assert property (p_start_rearms)
    else $error("start condition did not restart select reception");

  property p_ack_after_byte;
    s_byte_in ##1 (st.state == ST_ACK) |-> s_ack_entered;
  endproperty
  a_ack_after_byte : assert property (p_ack_after_byte)
    else $error("ack not driven low after eighth bit");

  property p_page_wrap;
    pbuf_we |=> (st.word_addr == {$past(st.word_addr[13:6]), $past(st.word_addr[5:0]) + 6'h01});
  endproperty
  a_page_wrap : assert property (p_page_wrap)
    else $error("page write address left its page");

  property p_busy_no_ack;
    ((st.state == ST_ACK) && (st.kind == K_DEV)) |-> !st.busy;
  endproperty
  a_busy_no_ack : assert property (p_busy_no_ack)
    else $error("select acknowledged during write cycle");

endmodule // tws_target

// >>> dv/tws_ctl_model.sv
// two-wire bus controller model: drives scl and an open-drain sda.
// assumes the bench resolves the sda wire with a pull-up; paced by clk_sys.
`timescale 1ns/1ps
module tws_ctl_model
  import tws_pkg::*;
(
  // clock
  input  wire logic clk_sys,
  // two-wire link
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_drv
);
  // scl stands high between frames; a released sda is pulled high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // start or repeated start: sda falls with scl high
  task automatic start();
    sda_drv <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(3);
  endtask

  // stop: sda rises with scl high
  task automatic stop();
    sda_drv <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask

  // one 200 ns bit; sda moves only mid-low, well clear of the filtered edges
  // the bit period is fixed here, so the controller alone sets scl pacing
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda_w;
    tick(1);
    scl <= 1'b0;
    tick(3);
  endtask

  // byte out msb first, then the ninth clock returns the target's ack
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask

  // byte in, then our own ack or no-ack on the ninth clock
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(mack, r);
  endtask
endmodule // tws_ctl_model

// >>> dv/tws_target_tb.sv
// bench for the two-wire memory target: registers, select, page write, protect.
// assumes the controller model in tws_ctl_model and a shortened write cycle.
`timescale 1ns/1ps
module tws_target_tb
  import tws_pkg::*;
;
  localparam int WR_SIM = 200;
  localparam logic [13:0] PG_ADDR = 14'h017E;

  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        scl;
  logic        sda_drv;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe_n;
  logic [2:0]  strap = 3'h5;
  logic        write_protect = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #12.5 clk_sys = ~clk_sys;
  // wired-and of both open-drain drivers over the pull-up
  assign sda_w = sda_drv & (sda_oe_n | sda_out);

  tws_target #(.WR_CYCLES(WR_SIM)) tws_target_i (
    .clk_sys(clk_sys), .reset(reset), .scl(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_addr_bit0(strap[0]),
    .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
    .write_protect(write_protect), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  tws_ctl_model tws_ctl_model_i (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl),
    .sda_drv(sda_drv));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch and closes the run
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single ahb-lite word transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic sel(input logic rw, output logic ack);
    tws_ctl_model_i.start();
    tws_ctl_model_i.send({DEV_PREFIX, strap, rw}, ack);
  endtask

  // load the 14-bit word address with a dummy write
  task automatic set_addr(input logic [13:0] a);
    logic ack;
    sel(1'b0, ack);
    check("select ack", 32'(ack), 32'h0);
    tws_ctl_model_i.send({2'h0, a[13:8]}, ack);
    check("addr hi ack", 32'(ack), 32'h0);
    tws_ctl_model_i.send(a[7:0], ack);
    check("addr lo ack", 32'(ack), 32'h0);
  endtask

  // write n bytes b0, b0+1, ... starting at a
  task automatic wr_link(input logic [13:0] a, input int n, input logic [7:0] b0);
    logic ack;
    set_addr(a);
    for (int i = 0; i < n; i++)
    begin
      tws_ctl_model_i.send(b0 + 8'(i), ack);
      check("data ack", 32'(ack), 32'h0);
    end
    tws_ctl_model_i.stop();
  endtask

  // random read of n bytes, expecting b0, b0+1, ...
  task automatic rd_link(input logic [13:0] a, input int n, input logic [7:0] b0);
    logic       ack;
    logic [7:0] d;
    set_addr(a);
    sel(1'b1, ack);
    check("read select ack", 32'(ack), 32'h0);
    for (int i = 0; i < n; i++)
    begin
      tws_ctl_model_i.recv(i == n - 1, d);
      check("read byte", 32'(d), 32'(b0 + 8'(i)));
    end
    tws_ctl_model_i.stop();
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic        ack;
    ahb(1'b0, CTRL_OFF, 32'h0, d);
    check("ctrl reset", d, 32'h1);
    check("hresp okay", 32'(hresp), 32'h0);
    check("hreadyout high", 32'(hreadyout), 32'h1);
    check("sda_out low", 32'(sda_out), 32'h0);
    ahb(1'b0, STATUS_OFF, 32'h0, d);
    check("status reset", d, 32'h0);
    ahb(1'b1, 8'h08, 32'hFFFFFFFF, d);
    ahb(1'b0, 8'h08, 32'h0, d);
    check("unmapped", d, 32'h0);
    // responding disabled: even a matching select goes unanswered
    ahb(1'b1, CTRL_OFF, 32'h0, d);
    sel(1'b0, ack);
    check("disabled select", 32'(ack), 32'h1);
    tws_ctl_model_i.stop();
    ahb(1'b1, CTRL_OFF, 32'h1, d);
    $display("test regs done");
  endtask

  // every strap code and a wrong prefix; only the strapped code answers
  task automatic t_select();
    logic ack;
    for (int i = 0; i < 9; i++)
    begin
      tws_ctl_model_i.start();
      tws_ctl_model_i.send({(i < 8) ? DEV_PREFIX : 4'h5, (i < 8) ? 3'(i) : strap, 1'b0},
                           ack);
      check("strap select", 32'(ack), {31'h0, i != 32'(strap)});
      tws_ctl_model_i.stop();
    end
    $display("test select done");
  endtask

  // page write across the page end, busy window, then read back
  task automatic t_page();
    logic [31:0] d;
    logic        ack;
    wr_link(PG_ADDR, 4, 8'hA0);
    repeat (8) @(posedge clk_sys);
    ahb(1'b0, STATUS_OFF, 32'h0, d);
    check("busy after stop", 32'(d[0]), 32'h1);
    check("addr after wrap", 32'(d[21:8]), 32'({PG_ADDR[13:6], 6'h02}));
    sel(1'b0, ack);
    check("select while busy", 32'(ack), 32'h1);
    tws_ctl_model_i.stop();
    // write cycle ends on its own, without link clocks
    for (int i = 0; i < 150 && d[0] !== 1'b0; i++)
      ahb(1'b0, STATUS_OFF, 32'h0, d);
    check("busy cleared", 32'(d[0]), 32'h0);
    rd_link(PG_ADDR, 2, 8'hA0);
    rd_link({PG_ADDR[13:6], 6'h00}, 2, 8'hA2);
    $display("test page done");
  endtask

  // protected write is acked but neither stored nor timed
  task automatic t_wp();
    logic [31:0] d;
    write_protect <= 1'b1;
    repeat (8) @(posedge clk_sys);
    ahb(1'b0, STATUS_OFF, 32'h0, d);
    check("wp seen", 32'(d[1]), 32'h1);
    wr_link(PG_ADDR, 1, 8'h55);
    repeat (8) @(posedge clk_sys);
    ahb(1'b0, STATUS_OFF, 32'h0, d);
    check("no cycle under wp", 32'(d[0]), 32'h0);
    rd_link(PG_ADDR, 1, 8'hA0);
    write_protect <= 1'b0;
    $display("test wp done");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (8) @(posedge clk_sys);
    t_regs();
    t_select();
    t_page();
    t_wp();
    print_verdict();
  end
endmodule // tws_target_tb
